// *** rtl/rgsa_axil.sv ***
// rgsa_axil: AXI4-Lite slave front end producing register strobes
`timescale 1ns/10ps
`default_nettype none
module rgsa_axil (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw;
    logic        w_got;
    logic [7:0]  wd;
    logic        wlow;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        stb;
  } rgsa_axi_t;

  rgsa_axi_t st_reg;
  rgsa_axi_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.stb = 1'b0;
    if (s_axil_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b1;
      st_next.aw     = s_axil_awaddr;
    end
    if (s_axil_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
      st_next.w_got = 1'b1;
      st_next.wd    = s_axil_wdata[7:0];
      st_next.wlow  = s_axil_wstrb[0];
    end
    // both halves held: perform the write and answer next cycle
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.stb    = st_reg.wlow;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_hit ? 2'h0 : 2'h2;
    end
    if (st_reg.bvalid && s_axil_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axil_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_hit ? rd_data : 32'h0000_0000;
      st_next.rresp  = rd_hit ? 2'h0 : 2'h2;
    end else if (st_reg.rvalid && s_axil_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axil_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axil_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axil_bvalid  = st_reg.bvalid;
  assign s_axil_bresp   = st_reg.bresp;
  assign s_axil_arready = !st_reg.rvalid;
  assign s_axil_rvalid  = st_reg.rvalid;
  assign s_axil_rdata   = st_reg.rdata;
  assign s_axil_rresp   = st_reg.rresp;
  assign wr_stb  = st_reg.stb;
  assign wr_addr = st_reg.aw;
  assign wr_data = st_reg.wd;
  assign rd_addr = s_axil_araddr;
endmodule : rgsa_axil
`default_nettype wire

// *** rtl/rgsa_edge_sync.sv ***
// rgsa_edge_sync: three-stage pin synchroniser with edge pulse
`timescale 1ns/10ps
`default_nettype none
module rgsa_edge_sync (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      level,
  output logic      edge_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic edg;
  } rgsa_sync_t;

  rgsa_sync_t st_reg;
  rgsa_sync_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.edg = 1'b0;
    // a change counts only once stages two and three agree
    if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.lvl) begin
      st_next.lvl = st_reg.s3;
      st_next.edg = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level      = st_reg.lvl;
  assign edge_pulse = st_reg.edg;
endmodule : rgsa_edge_sync
`default_nettype wire

// *** rtl/rgsa_pkg.sv ***
// rgsa_pkg: register map, field layout and timing constants
package rgsa_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] RGSA_OFS_CFG2   = 8'h00;
  localparam logic [7:0] RGSA_OFS_CFG3   = 8'h04;
  localparam logic [7:0] RGSA_OFS_CFG4   = 8'h08;
  localparam logic [7:0] RGSA_OFS_CMD    = 8'h0c;
  localparam logic [7:0] RGSA_OFS_GAIN   = 8'h10;
  localparam logic [7:0] RGSA_OFS_RSSI   = 8'h14;
  localparam logic [7:0] RGSA_OFS_STATUS = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RGSA_CFG2_AGC_EN   = 0;
  localparam int RGSA_CFG2_AGC_M    = 1;
  localparam int RGSA_CFG2_AGC_ALG  = 2;
  localparam int RGSA_CFG2_SQM_DYN  = 3;
  localparam int RGSA_CFG3_LIM      = 0;
  localparam int RGSA_CFG3_FORCED   = 1;
  localparam int RGSA_CFG4_MANUAL   = 4;
  localparam int RGSA_CMD_RST_GAIN  = 0;
  localparam int RGSA_CMD_SQUELCH   = 1;
  localparam int RGSA_CMD_CLR_RSSI  = 2;
  localparam int RGSA_CMD_PRESET    = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RGSA_CFG2_RST = 4'h5;
  localparam logic [1:0] RGSA_CFG3_RST = 2'h0;
  localparam logic [4:0] RGSA_CFG4_RST = 5'h00;
  localparam logic [1:0] RGSA_CFG3_NFC = 2'h3;

  // ****************************************
  // gain-reduction codes
  // ****************************************
  localparam logic [3:0] RGSA_GR_MAX    = 4'ha;
  localparam logic [3:0] RGSA_GR_PRESET = 4'h4;
  localparam logic [3:0] RGSA_GR_ZERO   = 4'h0;
  localparam logic [3:0] RGSA_WIN_MAX   = 4'h4;
  localparam logic [3:0] RGSA_FORCED_GR = 4'h6;
  localparam logic [3:0] RGSA_RSSI_MAX  = 4'hd;
  localparam logic [7:0] RGSA_SQ_LIMIT  = 8'h02;
  localparam logic [3:0] RGSA_AGC_PULSES = 4'h8;

  // ****************************************
  // timing
  // ****************************************
  localparam int RGSA_CLK_MHZ      = 100;
  localparam int RGSA_SQ_WIN_NS    = 50000;
  localparam int RGSA_SQ_DELAY_NS  = 18880;
  localparam int RGSA_SQ_WIN_CYC   = RGSA_SQ_WIN_NS * RGSA_CLK_MHZ / 1000;
  localparam int RGSA_SQ_DELAY_CYC =
    (RGSA_SQ_DELAY_NS * RGSA_CLK_MHZ + 999) / 1000;

endpackage : rgsa_pkg

// *** rtl/rgsa_top.sv ***
// rgsa_top: receiver gain, squelch, AGC and signal-strength control
//
// Overview of operation
// - window comparator has five 3 dB settings, from loops or manual value
// - gain-reduction state has eleven codes; window first, then stage gain
// - squelch steps on from the current code; AGC starts from its preset code
// - squelch counts digitizer edges per 50 us; above two steps up
// - squelch stops at two or fewer edges or at maximum code
// - squelch reduction clears on the reset-gain command or at AGC start
// - dynamic squelch runs 18.88 us after transmit until mask timer ends
// - squelch command accepted only while receive-active is low
// - AGC starts at receive-active rise, resets at its fall
// - code captured to gain register on each receive-active fall
// - AGC steps while auxiliary comparator shows edges
// - AGC enable, mode and algorithm bits in configuration two
// - AGC runs whole reception or first eight sub-carrier pulses
// - AGC start presets code four, or zero under other algorithm
// - after reset AGC enabled, full reception, preset algorithm
// - strength measured while receive-active high, frozen when low
// - strength is peak hold from zero, cleared when AGC steps
// - strength codes are four bits, never above thirteen
// - clear-strength command zeroes results and restarts peak hold
// - clip enable bit in configuration three drives limiters
// - forced peer reduction fixes stage gain and maximum window
// - analog preset command loads peer-mode receiver bits
// - reset-gain command resets loops and loads initial code
`timescale 1ns/10ps
`default_nettype none
module rgsa_top
  import rgsa_pkg::*;
#(
  parameter int SQ_WIN_CYC   = RGSA_SQ_WIN_CYC,
  parameter int SQ_DELAY_CYC = RGSA_SQ_DELAY_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic        rx_on,
  input  wire logic        tx_end,
  input  wire logic        mask_rx_expire,
  input  wire logic        digitizer_in,
  input  wire logic        aux_comp_in,
  input  wire logic [3:0]  strength_a_in,
  input  wire logic [3:0]  strength_b_in,
  output logic [2:0]       window_sel,
  output logic [2:0]       stage_gain_red,
  output logic             clip_en
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (SQ_WIN_CYC < 1 || SQ_WIN_CYC > 65535 ||
      SQ_DELAY_CYC < 1 || SQ_DELAY_CYC > 65535) begin : g_chk
    $error("rgsa_top: timing parameter out of range");
  end

  localparam logic [15:0] WIN_LAST = 16'(SQ_WIN_CYC - 1);
  localparam logic [15:0] DLY_LAST = 16'(SQ_DELAY_CYC - 1);

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b00,
    SQ_DELAY = 2'b01,
    SQ_RUN   = 2'b10
  } rgsa_sq_t;

  typedef struct packed {
    logic [3:0]  cfg2;
    logic [1:0]  cfg3;
    logic [4:0]  cfg4;
    logic [3:0]  code;
    logic [3:0]  captured;
    logic [3:0]  rssi_a;
    logic [3:0]  rssi_b;
    rgsa_sq_t    sq;
    logic        sq_dyn;
    logic [15:0] win_cnt;
    logic [15:0] dly_cnt;
    logic [7:0]  edges;
    logic        agc_act;
    logic        rssi_act;
    logic [3:0]  pulses;
    logic        rx_prev;
    logic [2:0]  win_o;
    logic [2:0]  gain_o;
    logic        clip_o;
  } rgsa_st_t;

  rgsa_st_t st_reg;
  rgsa_st_t st_next;

  // ****************************************
  // register bus
  // ****************************************
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;

  rgsa_axil u_axil (
    .ref_clk        (ref_clk),
    .nrst           (nrst),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_stb         (wr_stb),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_hit         (rd_hit),
    .wr_hit         (wr_hit)
  );

  // ****************************************
  // comparator synchronisers
  // ****************************************
  logic dig_lvl;
  logic dig_edge;
  logic aux_lvl;
  logic aux_edge;

  rgsa_edge_sync u_dig_sync (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .pin_in     (digitizer_in),
    .level      (dig_lvl),
    .edge_pulse (dig_edge)
  );

  rgsa_edge_sync u_aux_sync (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .pin_in     (aux_comp_in),
    .level      (aux_lvl),
    .edge_pulse (aux_edge)
  );

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      RGSA_OFS_CFG2:   rd_data[3:0] = st_reg.cfg2;
      RGSA_OFS_CFG3:   rd_data[1:0] = st_reg.cfg3;
      RGSA_OFS_CFG4:   rd_data[4:0] = st_reg.cfg4;
      RGSA_OFS_CMD:    rd_data      = 32'h0000_0000;
      RGSA_OFS_GAIN:   rd_data[7:0] = {st_reg.captured, st_reg.code};
      RGSA_OFS_RSSI:   rd_data[7:0] = {st_reg.rssi_b, st_reg.rssi_a};
      RGSA_OFS_STATUS: rd_data[3:0] = {st_reg.sq != SQ_IDLE,
                                       st_reg.agc_act, dig_lvl, aux_lvl};
      default:         rd_hit = 1'b0;
    endcase
  end

  assign wr_hit = (wr_addr == RGSA_OFS_CFG2) || (wr_addr == RGSA_OFS_CFG3) ||
                  (wr_addr == RGSA_OFS_CFG4) || (wr_addr == RGSA_OFS_CMD);

  // ****************************************
  // loop control
  // ****************************************
  logic       cmd_rst;
  logic       cmd_sq;
  logic       cmd_clr;
  logic       cmd_pre;
  logic       rx_rise;
  logic       rx_fall;
  logic       agc_step;
  logic       sq_step;
  logic [3:0] init_code;
  logic [3:0] code_step;
  logic [3:0] eff;

  always_comb begin
    cmd_rst = wr_stb && wr_addr == RGSA_OFS_CMD &&
              wr_data[RGSA_CMD_RST_GAIN];
    // squelch command only while receive-active low
    cmd_sq  = wr_stb && wr_addr == RGSA_OFS_CMD &&
              wr_data[RGSA_CMD_SQUELCH] && !rx_on;
    cmd_clr = wr_stb && wr_addr == RGSA_OFS_CMD &&
              wr_data[RGSA_CMD_CLR_RSSI];
    cmd_pre = wr_stb && wr_addr == RGSA_OFS_CMD &&
              wr_data[RGSA_CMD_PRESET];
    rx_rise = rx_on && !st_reg.rx_prev;
    rx_fall = !rx_on && st_reg.rx_prev;
    init_code = (st_reg.cfg4[3:0] > RGSA_GR_MAX) ? RGSA_GR_MAX
                                                 : st_reg.cfg4[3:0];
    code_step = (st_reg.code == RGSA_GR_MAX) ? st_reg.code
                                             : st_reg.code + 4'h1;
    agc_step = st_reg.agc_act && aux_edge && st_reg.code != RGSA_GR_MAX;
    sq_step  = st_reg.sq == SQ_RUN && st_reg.win_cnt == WIN_LAST &&
               st_reg.edges > RGSA_SQ_LIMIT;
    // manual value or loop code drives the window
    eff = st_reg.cfg4[RGSA_CFG4_MANUAL] ? init_code : st_reg.code;
  end

  always_comb begin
    st_next         = st_reg;
    st_next.rx_prev = rx_on;

    if (wr_stb && wr_addr == RGSA_OFS_CFG2) begin
      st_next.cfg2 = wr_data[3:0];
    end
    if (wr_stb && wr_addr == RGSA_OFS_CFG3) begin
      st_next.cfg3 = wr_data[1:0];
    end
    if (wr_stb && wr_addr == RGSA_OFS_CFG4) begin
      st_next.cfg4 = wr_data[4:0];
    end
    if (cmd_pre) begin
      st_next.cfg3 = RGSA_CFG3_NFC;
    end

    if (tx_end && st_reg.cfg2[RGSA_CFG2_SQM_DYN] && st_reg.sq == SQ_IDLE) begin
      st_next.sq      = SQ_DELAY;
      st_next.sq_dyn  = 1'b1;
      st_next.dly_cnt = 16'h0000;
    end else if (cmd_sq && st_reg.sq == SQ_IDLE) begin
      st_next.sq      = SQ_RUN;
      st_next.sq_dyn  = 1'b0;
      st_next.win_cnt = 16'h0000;
      st_next.edges   = 8'h00;
    end

    case (st_reg.sq)
      SQ_IDLE: begin
      end
      SQ_DELAY: begin
        st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
        if (st_reg.dly_cnt == DLY_LAST) begin
          st_next.sq      = SQ_RUN;
          st_next.win_cnt = 16'h0000;
          st_next.edges   = 8'h00;
        end
      end
      SQ_RUN: begin
        st_next.win_cnt = st_reg.win_cnt + 16'h0001;
        if (dig_edge && st_reg.edges != 8'hff) begin
          st_next.edges = st_reg.edges + 8'h01;
        end
        if (st_reg.win_cnt == WIN_LAST) begin
          st_next.win_cnt = 16'h0000;
          st_next.edges   = 8'h00;
          // quiet window or max code ends squelch
          if (!sq_step || code_step == RGSA_GR_MAX) begin
            st_next.sq = SQ_IDLE;
          end
        end
      end
      default: st_next.sq = SQ_IDLE;
    endcase
    if (st_reg.sq != SQ_IDLE && st_reg.sq_dyn && mask_rx_expire) begin
      st_next.sq = SQ_IDLE;
    end
    if (sq_step) begin
      st_next.code = code_step;
    end

    // AGC lives from receive-active rise to fall
    if (rx_rise && st_reg.cfg2[RGSA_CFG2_AGC_EN]) begin
      st_next.agc_act = 1'b1;
      st_next.pulses  = 4'h0;
      st_next.code = st_reg.cfg2[RGSA_CFG2_AGC_ALG] ? RGSA_GR_PRESET
                                                    : RGSA_GR_ZERO;
    end
    if (agc_step) begin
      st_next.code = code_step;
    end
    // short mode stops after eight pulses
    if (st_reg.agc_act && st_reg.cfg2[RGSA_CFG2_AGC_M] && dig_edge &&
        dig_lvl) begin
      st_next.pulses = st_reg.pulses + 4'h1;
      if (st_reg.pulses == RGSA_AGC_PULSES - 4'h1) begin
        st_next.agc_act = 1'b0;
      end
    end

    // strength active only while receive-active high
    if (rx_rise) begin
      st_next.rssi_act = 1'b1;
      st_next.rssi_a   = 4'h0;
      st_next.rssi_b   = 4'h0;
    end else if (st_reg.rssi_act && rx_on) begin
      // peak hold, cleared on AGC step
      if (agc_step) begin
        st_next.rssi_a = 4'h0;
        st_next.rssi_b = 4'h0;
      end else begin
        if (strength_a_in > st_reg.rssi_a) begin
          st_next.rssi_a = (strength_a_in > RGSA_RSSI_MAX) ? RGSA_RSSI_MAX
                                                          : strength_a_in;
        end
        if (strength_b_in > st_reg.rssi_b) begin
          st_next.rssi_b = (strength_b_in > RGSA_RSSI_MAX) ? RGSA_RSSI_MAX
                                                          : strength_b_in;
        end
      end
    end
    if (cmd_clr) begin
      st_next.rssi_a = 4'h0;
      st_next.rssi_b = 4'h0;
    end

    if (rx_fall) begin
      st_next.captured = st_reg.code;
      st_next.agc_act  = 1'b0;
      st_next.rssi_act = 1'b0;
    end

    // this command and AGC start clear squelch reduction
    // reset loops and load initial code
    if (cmd_rst) begin
      st_next.code     = init_code;
      st_next.sq       = SQ_IDLE;
      st_next.agc_act  = 1'b0;
      st_next.rssi_act = 1'b0;
      st_next.rssi_a   = 4'h0;
      st_next.rssi_b   = 4'h0;
    end

    // map code to window step then stage gain step
    if (st_reg.cfg3[RGSA_CFG3_FORCED]) begin
      st_next.win_o  = RGSA_WIN_MAX[2:0];
      st_next.gain_o = 3'h2;
    end else if (eff > RGSA_WIN_MAX) begin
      st_next.win_o  = RGSA_WIN_MAX[2:0];
      st_next.gain_o = 3'(eff - RGSA_WIN_MAX);
    end else begin
      st_next.win_o  = eff[2:0];
      st_next.gain_o = 3'h0;
    end
    st_next.clip_o = st_reg.cfg3[RGSA_CFG3_LIM];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      // AGC on, full reception, preset algorithm
      st_reg.cfg2 <= RGSA_CFG2_RST;
      st_reg.cfg3 <= RGSA_CFG3_RST;
      st_reg.cfg4 <= RGSA_CFG4_RST;
      st_reg.sq   <= SQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign window_sel     = st_reg.win_o;
  assign stage_gain_red = st_reg.gain_o;
  assign clip_en        = st_reg.clip_o;

endmodule : rgsa_top
`default_nettype wire

// *** testbench/rgsa_asserts.sv ***
// rgsa_asserts: port-level checks for the gain and strength control block
`timescale 1ns/10ps
`default_nettype none
module rgsa_asserts (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0]  s_axil_rresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        rx_on,
  input wire logic [2:0]  window_sel,
  input wire logic [2:0]  stage_gain_red,
  input wire logic        clip_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_window_range: assert property (
    window_sel <= 3'h4) else $error("window step out of range");
  a_stage_sat: assert property (
    stage_gain_red <= 3'h6) else $error("stage reduction out of range");
  a_window_first: assert property (
    stage_gain_red != 3'h0 |-> window_sel == 3'h4)
    else $error("stage gain cut before window is wide");
  a_read_answer: assert property (
    s_axil_arvalid && !s_axil_rvalid |=> s_axil_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (
    s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read answer dropped");
  a_write_hold: assert property (
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write answer dropped");
  a_resp_legal: assert property (
    s_axil_rvalid |-> s_axil_rresp inside {2'h0, 2'h2})
    else $error("bad read response");
  // clip bit only moves as a result of a register write
  a_clip_cause: assert property (
    $changed(clip_en) |-> $past(s_axil_bvalid, 2))
    else $error("clip enable moved without a write");
  c_rx: cover property ($rose(rx_on));
  c_sat: cover property (stage_gain_red == 3'h6);
  c_clip: cover property ($rose(clip_en));
endmodule : rgsa_asserts
bind rgsa_top rgsa_asserts u_chk (.*);
`default_nettype wire

// *** testbench/rgsa_axil_master.sv ***
// rgsa_axil_master: controller model speaking AXI4-Lite to the block
`timescale 1ns/10ps
`default_nettype none
module rgsa_axil_master (
  input wire logic        ref_clk,
  output logic [7:0]      s_axil_awaddr,
  output logic            s_axil_awvalid,
  input wire logic        s_axil_awready,
  output logic [31:0]     s_axil_wdata,
  output logic [3:0]      s_axil_wstrb,
  output logic            s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic        s_axil_bvalid,
  output logic            s_axil_bready,
  output logic [7:0]      s_axil_araddr,
  output logic            s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic        s_axil_rvalid,
  output logic            s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0]  s_axil_rresp
);
  initial begin
    {s_axil_awaddr, s_axil_awvalid, s_axil_wdata, s_axil_wvalid} = '0;
    {s_axil_bready, s_axil_araddr, s_axil_arvalid, s_axil_rready} = '0;
    s_axil_wstrb = 4'hf;
  end
  // address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit at;
    bit wt;
    bit bh;
    @(posedge ref_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      // settled handshakes, half a period before the edge that takes them
      @(negedge ref_clk);
      at = s_axil_awvalid && s_axil_awready;
      wt = s_axil_wvalid && s_axil_wready;
      bh = s_axil_bvalid === 1'b1;
      @(posedge ref_clk);
      if (at) s_axil_awvalid <= 1'b0;
      if (wt) s_axil_wvalid <= 1'b0;
    end while (!bh);
    s_axil_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit at;
    bit rh;
    @(posedge ref_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      at = s_axil_arvalid && s_axil_arready;
      rh = s_axil_rvalid === 1'b1;
      d = s_axil_rdata;
      r = s_axil_rresp;
      @(posedge ref_clk);
      if (at) s_axil_arvalid <= 1'b0;
    end while (!rh);
    s_axil_rready <= 1'b0;
  endtask : rd
endmodule : rgsa_axil_master
`default_nettype wire

// *** testbench/rgsa_top_test.sv ***
// rgsa_top_test: self-checking bench for the gain control block
`timescale 1ns/10ps
`default_nettype none
module rgsa_top_test;
  import rgsa_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, rx_on = 1'b0, noise = 1'b0;
  logic tx_end = 1'b0, mask_rx_expire = 1'b0;
  logic digitizer_in = 1'b0, aux_comp_in = 1'b0;
  logic [3:0] strength_a_in = 4'h0, strength_b_in = 4'h0;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, d;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, r;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic s_axil_rvalid, s_axil_rready, clip_en;
  logic [2:0] window_sel, stage_gain_red;
  int n_mismatch = 0, num_checks = 0;
  // address, expected data, expected response
  logic [41:0] rows [6] = '{{8'h00, 32'h5, 2'h0}, {8'h04, 32'h0, 2'h0},
    {8'h08, 32'h0, 2'h0}, {8'h0c, 32'h0, 2'h0}, {8'h10, 32'h0, 2'h0},
    {8'h1c, 32'h0, 2'h2}};
  always #5 ref_clk = ~ref_clk;
  logic ph = 1'b0;
  // levels held two cycles so the filter takes them: ten edges per window
  always @(posedge ref_clk) if (noise) begin
    ph <= !ph;
    if (ph) digitizer_in <= !digitizer_in;
  end
  rgsa_top #(.SQ_WIN_CYC(20), .SQ_DELAY_CYC(2)) DUT (.*);
  rgsa_axil_master m (.*);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc
  function automatic logic [31:0] code(input logic [2:0] w, input logic [2:0] s);
    return {26'h0, w, s};
  endfunction : code
  initial begin
    #200000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    wait_cyc(20);
    nrst <= 1'b1;
    chk({clip_en, window_sel, stage_gain_red}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      m.rd(rows[i][41:34], d, r);
      chk(d, rows[i][33:2]);
      chk({30'h0, r}, {30'h0, rows[i][1:0]});
    end
    m.wr(RGSA_OFS_CFG3, 32'h1);
    wait_cyc(3);
    chk(clip_en, 1'b1);
    m.wr(RGSA_OFS_CFG3, 32'h2);
    wait_cyc(3);
    chk(code(window_sel, stage_gain_red), code(3'h4, 3'h2));
    // analog preset issued after peer mode is configured
    m.wr(RGSA_OFS_CMD, 32'h8);
    m.rd(RGSA_OFS_CFG3, d, r);
    chk(d, 32'h3);
    m.wr(RGSA_OFS_CFG3, 32'h0);
    m.wr(RGSA_OFS_CFG4, 32'h3);
    m.wr(RGSA_OFS_CMD, 32'h1);
    wait_cyc(3);
    chk(code(window_sel, stage_gain_red), code(3'h3, 3'h0));
    noise <= 1'b1;
    // squelch only while receive-active is low
    m.wr(RGSA_OFS_CMD, 32'h2);
    wait_cyc(400);
    chk(code(window_sel, stage_gain_red), code(3'h4, 3'h6));
    noise <= 1'b0;
    m.wr(RGSA_OFS_CMD, 32'h1);
    m.wr(RGSA_OFS_CMD, 32'h2);
    wait_cyc(100);
    chk(code(window_sel, stage_gain_red), code(3'h3, 3'h0));
    rx_on <= 1'b1;
    wait_cyc(10);
    chk(code(window_sel, stage_gain_red), code(3'h4, 3'h0));
    strength_a_in <= 4'hf;
    strength_b_in <= 4'h9;
    wait_cyc(10);
    rx_on <= 1'b0;
    wait_cyc(5);
    strength_b_in <= 4'hc;
    m.rd(RGSA_OFS_RSSI, d, r);
    chk(d, 32'h9d);
    m.rd(RGSA_OFS_GAIN, d, r);
    chk(d & 32'hf0, 32'h40);
    m.rd(RGSA_OFS_RSSI, d, r);
    chk(d, 32'h9d);
    m.wr(RGSA_OFS_CMD, 32'h4);
    m.rd(RGSA_OFS_RSSI, d, r);
    chk(d, 32'h0);
    m.wr(RGSA_OFS_CFG2, 32'h3);
    rx_on <= 1'b1;
    wait_cyc(10);
    chk(code(window_sel, stage_gain_red), code(3'h0, 3'h0));
    strength_a_in <= 4'h2;
    aux_comp_in <= 1'b1;
    wait_cyc(10);
    chk(code(window_sel, stage_gain_red), code(3'h1, 3'h0));
    m.rd(RGSA_OFS_RSSI, d, r);
    chk(d, 32'hc2);
    // short mode: past eight pulses a further comparator edge is ignored
    noise <= 1'b1;
    wait_cyc(50);
    noise <= 1'b0;
    aux_comp_in <= 1'b0;
    wait_cyc(10);
    chk(code(window_sel, stage_gain_red), code(3'h1, 3'h0));
    rx_on <= 1'b0;
    stop_test;
  end
endmodule : rgsa_top_test
`default_nettype wire
